// *** rtl/ssc_host.sv ***
// host controller: runs health check, crc test and reset on the sensor bank
`timescale 1ns/10ps
module ssc_host #(
  parameter int unsigned FRAME_CYCLES = ssc_pkg::FRAME_CYCLES_DEF,
  parameter int unsigned CRC_WAIT = ssc_pkg::CRC_WAIT_DEF
) (
  input wire logic mclk_i,            // 100 MHz clock
  input wire logic nrst_i,            // async reset, active low
  ssc_bus_if.host bus,                // register link to sensor
  input wire logic [7:0] sw_addr_i,   // software address
  input wire logic [15:0] sw_wdata_i, // software write data
  input wire logic sw_wr_i,           // software write strobe
  input wire logic sw_rd_i,           // software read strobe
  output logic [15:0] sw_rdata_o,     // read data, cycle after strobe
  output logic irq_o                  // level interrupt
);
  import ssc_pkg::*;

  ssc_hstate_type st_r;
  ssc_op_type op_r;
  logic [31:0] wait_r;
  logic second_r;
  logic [7:0] raw_addr_r;
  logic [7:0] raw_wdata_r;
  logic [7:0] result_r;
  logic [15:0] crc_r;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] irq_stat_r;
  logic [EVT_W-1:0] irq_en_r;
  logic ctl_wr;
  logic idle;

  assign ctl_wr = sw_wr_i && (sw_addr_i == SW_CTRL);
  assign idle = (st_r == HST_IDLE);

  // software side registers
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      raw_addr_r <= '0;
      raw_wdata_r <= '0;
      irq_en_r <= '0;
    end
    else if (sw_wr_i)
    begin
      if (sw_addr_i == SW_RAW_ADDR)
        raw_addr_r <= sw_wdata_i[7:0];
      else if (sw_addr_i == SW_RAW_WDATA)
        raw_wdata_r <= sw_wdata_i[7:0];
      else if (sw_addr_i == SW_IRQ_ENABLE)
        irq_en_r <= sw_wdata_i[EVT_W-1:0];
    end
  end

  // sequencer and link strobes
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= HST_IDLE;
      op_r <= OP_NONE;
      wait_r <= '0;
      second_r <= 1'b0;
      bus.addr <= '0;
      bus.wdata <= '0;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      result_r <= '0;
      crc_r <= '0;
      evt <= '0;
    end
    else
    begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      evt <= '0;
      case (st_r)
        HST_IDLE:
        begin
          if (ctl_wr && sw_wdata_i[CTL_HEALTH])
          begin
            bus.wr <= 1'b1;
            bus.addr <= ADDR_PROC_OBS;
            bus.wdata <= OBS_CLEAR_VAL;
            wait_r <= FRAME_CYCLES + 1;
            op_r <= OP_HEALTH;
            st_r <= HST_WAIT;
          end
          else if (ctl_wr && sw_wdata_i[CTL_CRC])
          begin
            bus.wr <= 1'b1;
            bus.addr <= ADDR_FWM_ENABLE;
            bus.wdata <= CMD_CRC_START;
            wait_r <= CRC_WAIT;
            second_r <= 1'b0;
            op_r <= OP_CRC;
            st_r <= HST_WAIT;
          end
          else if (ctl_wr && sw_wdata_i[CTL_RESET])
          begin
            bus.wr <= 1'b1;
            bus.addr <= ADDR_PUR_CMD;
            bus.wdata <= CMD_PUR;
            evt[EVT_RAW] <= 1'b1;
          end
          else if (ctl_wr && sw_wdata_i[CTL_RAW_WR])
          begin
            bus.wr <= 1'b1;
            bus.addr <= raw_addr_r;
            bus.wdata <= raw_wdata_r;
            evt[EVT_RAW] <= 1'b1;
          end
          else if (ctl_wr && sw_wdata_i[CTL_RAW_RD])
          begin
            op_r <= OP_RAW;
            st_r <= HST_RD;
          end
        end
        HST_WAIT:
        begin
          wait_r <= wait_r - 32'd1;
          if (wait_r == 32'd1)
            st_r <= HST_RD;
        end
        HST_RD:
        begin
          bus.rd <= 1'b1;
          if (op_r == OP_HEALTH)
            bus.addr <= ADDR_PROC_OBS;
          else if (op_r == OP_CRC)
            bus.addr <= second_r ? ADDR_CRC_LOW : ADDR_CRC_HIGH;
          else
            bus.addr <= raw_addr_r;
          st_r <= HST_HOLD;
        end
        HST_HOLD:
          st_r <= HST_CAP;
        HST_CAP:
        begin
          st_r <= HST_IDLE;
          case (op_r)
            OP_HEALTH:
            begin
              result_r <= bus.rdata;
              evt[EVT_HEALTH] <= 1'b1;
            end
            OP_CRC:
            begin
              if (second_r)
              begin
                crc_r[7:0] <= bus.rdata;
                evt[EVT_CRC] <= 1'b1;
              end
              else
              begin
                crc_r[15:8] <= bus.rdata;
                second_r <= 1'b1;
                st_r <= HST_RD;
              end
            end
            default:
            begin
              result_r <= bus.rdata;
              evt[EVT_RAW] <= 1'b1;
            end
          endcase
        end
        default:
          st_r <= HST_IDLE;
      endcase
    end
  end

  // sticky event bits, a new event wins over a clear
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_stat_r <= '0;
    else if (sw_wr_i && (sw_addr_i == SW_IRQ_CLEAR))
      irq_stat_r <= (irq_stat_r & ~sw_wdata_i[EVT_W-1:0]) | evt;
    else
      irq_stat_r <= irq_stat_r | evt;
  end

  // interrupt level and software read data
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_o <= 1'b0;
      sw_rdata_o <= '0;
    end
    else
    begin
      irq_o <= |(irq_stat_r & irq_en_r);
      if (sw_rd_i)
      begin
        if (sw_addr_i == SW_RAW_ADDR)
          sw_rdata_o <= {8'h00, raw_addr_r};
        else if (sw_addr_i == SW_RAW_WDATA)
          sw_rdata_o <= {8'h00, raw_wdata_r};
        else if (sw_addr_i == SW_RESULT)
          sw_rdata_o <= {8'h00, result_r};
        else if (sw_addr_i == SW_CRC)
          sw_rdata_o <= crc_r;
        else if (sw_addr_i == SW_STATUS)
          sw_rdata_o <= {14'h0000, crc_r == CRC_PASS, !idle};
        else if (sw_addr_i == SW_IRQ_STATUS)
          sw_rdata_o <= {13'h0000, irq_stat_r};
        else if (sw_addr_i == SW_IRQ_ENABLE)
          sw_rdata_o <= {13'h0000, irq_en_r};
        else
          sw_rdata_o <= '0;
      end
    end
  end
endmodule

// *** rtl/ssc_pkg.sv ***
// constants and types shared by the sensor register bank and its host controller
package ssc_pkg;
  // clock and frame timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FRAME_NS = 100000;
  localparam int unsigned FRAME_CYCLES_DEF = FRAME_NS / CLK_PERIOD_NS;
  // device register offsets
  localparam logic [7:0] ADDR_PROC_OBS = 8'h24;
  localparam logic [7:0] ADDR_CRC_LOW = 8'h25;
  localparam logic [7:0] ADDR_CRC_HIGH = 8'h26;
  localparam logic [7:0] ADDR_FW_REV = 8'h2A;
  localparam logic [7:0] ADDR_LIFT_THR = 8'h2E;
  localparam logic [7:0] ADDR_Y_RES = 8'h2F;
  localparam logic [7:0] ADDR_IMG_SIZE = 8'h39;
  localparam logic [7:0] ADDR_PUR_CMD = 8'h3A;
  localparam logic [7:0] ADDR_FWM_ENABLE = 8'h13;
  // device reset values, masks and command codes
  localparam logic [7:0] RST_PROC_OBS = 8'h00;
  localparam logic [7:0] RST_FW_REV = 8'h00;
  localparam logic [7:0] RST_LIFT_THR = 8'h10;
  localparam logic [7:0] RST_Y_RES = 8'h09;
  localparam logic [7:0] RST_IMG_SIZE = 8'h00;
  localparam logic [7:0] MASK_LIFT_THR = 8'h1F;
  localparam logic [7:0] MASK_IMG_SIZE = 8'h02;
  localparam logic [7:0] MASK_FRAME_FLAGS = 8'h3F;
  localparam logic [7:0] MASK_OBS_STORED = 8'hBF;
  localparam int unsigned BIT_FW_RUNNING = 6;
  localparam int unsigned BIT_IMG_SIZE = 1;
  localparam logic [7:0] OBS_CLEAR_VAL = 8'h00;
  localparam logic [7:0] CMD_CRC_START = 8'h15;
  localparam logic [7:0] CMD_PUR = 8'h5A;
  localparam logic [7:0] Y_RES_MIN = 8'h01;
  localparam logic [7:0] Y_RES_MAX = 8'h29;
  localparam logic [15:0] Y_CPI_STEP = 16'h00C8;
  // shadow firmware image
  localparam logic [11:0] IMG_SMALL_BYTES = 12'h600;
  localparam logic [11:0] IMG_LARGE_BYTES = 12'hC00;
  localparam int unsigned IMG_MEM_DEPTH = 3072;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PASS = 16'hBEEF;
  localparam int unsigned CRC_WAIT_DEF = IMG_MEM_DEPTH + 8;
  // host software register offsets
  localparam logic [7:0] SW_CTRL = 8'h00;
  localparam logic [7:0] SW_RAW_ADDR = 8'h04;
  localparam logic [7:0] SW_RAW_WDATA = 8'h08;
  localparam logic [7:0] SW_RESULT = 8'h0C;
  localparam logic [7:0] SW_CRC = 8'h10;
  localparam logic [7:0] SW_STATUS = 8'h14;
  localparam logic [7:0] SW_IRQ_STATUS = 8'h18;
  localparam logic [7:0] SW_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] SW_IRQ_ENABLE = 8'h20;
  // host control bits and interrupt events
  localparam int unsigned CTL_HEALTH = 0;
  localparam int unsigned CTL_CRC = 1;
  localparam int unsigned CTL_RESET = 2;
  localparam int unsigned CTL_RAW_WR = 3;
  localparam int unsigned CTL_RAW_RD = 4;
  localparam int unsigned EVT_HEALTH = 0;
  localparam int unsigned EVT_CRC = 1;
  localparam int unsigned EVT_RAW = 2;
  localparam int unsigned EVT_W = 3;

  // host sequencer states
  typedef enum logic [4:0] {
    HST_IDLE = 5'b00001,
    HST_WAIT = 5'b00010,
    HST_RD = 5'b00100,
    HST_HOLD = 5'b01000,
    HST_CAP = 5'b10000
  } ssc_hstate_type;

  // operation kinds carried by the host sequencer
  typedef enum logic [3:0] {
    OP_HEALTH = 4'b0001,
    OP_CRC = 4'b0010,
    OP_RAW = 4'b0100,
    OP_NONE = 4'b1000
  } ssc_op_type;
endpackage

// *** rtl/ssc_bus_if.sv ***
// register access link between host controller and sensor register bank
`timescale 1ns/10ps
interface ssc_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// *** rtl/ssc_device.sv ***
// sensor register bank: self-check flags, firmware crc test, configuration
`timescale 1ns/10ps
module ssc_device #(
  parameter int unsigned FRAME_CYCLES = ssc_pkg::FRAME_CYCLES_DEF
) (
  input wire logic mclk_i,              // 100 MHz clock
  input wire logic nrst_i,              // async reset, active low
  ssc_bus_if.dev bus,                   // register link from host
  input wire logic load_valid_i,        // firmware image byte strobe
  input wire logic [7:0] load_byte_i,   // firmware image byte
  input wire logic fw_running_i,        // core executes shadow firmware
  input wire logic [7:0] fw_revision_i, // revision of loaded image
  input wire logic indep_axis_i,        // independent-axis reporting mode
  input wire logic [15:0] common_cpi_i, // shared axis resolution in cpi
  output logic [4:0] lift_threshold_o,  // lift threshold field
  output logic [15:0] y_cpi_o,          // effective y resolution in cpi
  output logic image_3k_o,              // image size bit
  output logic crc_busy_o,              // crc test in progress
  output logic fw_loaded_o              // whole image downloaded
);
  import ssc_pkg::*;

  // one crc-16 step over a byte, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic [7:0] b);
    logic [15:0] c;
    c = acc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  logic soft_rst_r;
  logic [31:0] frame_cnt_r;
  logic frame_tick;
  logic [7:0] obs_r;
  logic [7:0] lift_r;
  logic [7:0] yres_r;
  logic [7:0] size_r;
  logic [7:0] mem_r [0:IMG_MEM_DEPTH-1];
  logic [11:0] load_cnt_r;
  logic [11:0] img_len;
  logic [11:0] crc_idx_r;
  logic [15:0] crc_acc_r;
  logic [15:0] crc_res_r;
  logic [15:0] crc_nxt;
  logic wr_obs;
  logic [7:0] rdata_r;

  assign frame_tick = (frame_cnt_r == FRAME_CYCLES - 1);
  assign wr_obs = bus.wr && (bus.addr == ADDR_PROC_OBS);
  assign img_len = size_r[BIT_IMG_SIZE] ? IMG_LARGE_BYTES : IMG_SMALL_BYTES;
  assign crc_nxt = crc_step(crc_acc_r, mem_r[crc_idx_r]);

  // power-up reset command, applied on the following edge
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= bus.wr && (bus.addr == ADDR_PUR_CMD) && (bus.wdata == CMD_PUR);
  end

  // frame timer
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      frame_cnt_r <= '0;
    else if (soft_rst_r || frame_tick)
      frame_cnt_r <= '0;
    else
      frame_cnt_r <= frame_cnt_r + 32'd1;
  end

  // process flags: frame set wins over host write
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      obs_r <= RST_PROC_OBS;
    else if (soft_rst_r)
      obs_r <= RST_PROC_OBS;
    else
      obs_r <= ((wr_obs ? bus.wdata : obs_r) | (frame_tick ? MASK_FRAME_FLAGS : 8'h00))
               & MASK_OBS_STORED;
  end

  // configuration registers
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lift_r <= RST_LIFT_THR;
      yres_r <= RST_Y_RES;
      size_r <= RST_IMG_SIZE;
    end
    else if (soft_rst_r)
    begin
      lift_r <= RST_LIFT_THR;
      yres_r <= RST_Y_RES;
      size_r <= RST_IMG_SIZE;
    end
    else if (bus.wr)
    begin
      if (bus.addr == ADDR_LIFT_THR)
        lift_r <= bus.wdata & MASK_LIFT_THR;
      else if (bus.addr == ADDR_Y_RES)
        yres_r <= bus.wdata;
      else if (bus.addr == ADDR_IMG_SIZE)
        size_r <= bus.wdata & MASK_IMG_SIZE;
    end
  end

  // image download into shadow firmware memory
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      load_cnt_r <= '0;
    else if (soft_rst_r)
      load_cnt_r <= '0;
    else if (load_valid_i && (load_cnt_r < img_len))
      load_cnt_r <= load_cnt_r + 12'd1;
  end

  // image memory has no reset
  always_ff @(posedge mclk_i)
  begin
    if (load_valid_i && (load_cnt_r < img_len))
      mem_r[load_cnt_r] <= load_byte_i;
  end

  // crc test over the loaded image
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      crc_busy_o <= 1'b0;
      crc_idx_r <= '0;
      crc_acc_r <= CRC_SEED;
      crc_res_r <= '0;
    end
    else if (soft_rst_r)
    begin
      crc_busy_o <= 1'b0;
      crc_idx_r <= '0;
      crc_acc_r <= CRC_SEED;
    end
    else if (bus.wr && (bus.addr == ADDR_FWM_ENABLE) && (bus.wdata == CMD_CRC_START))
    begin
      crc_busy_o <= 1'b1;
      crc_idx_r <= '0;
      crc_acc_r <= CRC_SEED;
    end
    else if (crc_busy_o)
    begin
      crc_acc_r <= crc_nxt;
      crc_idx_r <= crc_idx_r + 12'd1;
      if (crc_idx_r == img_len - 12'd1)
      begin
        crc_busy_o <= 1'b0;
        crc_res_r <= crc_nxt;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_r <= '0;
    else if (bus.rd)
    begin
      if (bus.addr == ADDR_PROC_OBS)
        rdata_r <= obs_r | ((fw_running_i ? 8'h01 : 8'h00) << BIT_FW_RUNNING);
      else if (bus.addr == ADDR_CRC_LOW)
        rdata_r <= crc_res_r[7:0];
      else if (bus.addr == ADDR_CRC_HIGH)
        rdata_r <= crc_res_r[15:8];
      else if (bus.addr == ADDR_FW_REV)
        rdata_r <= (fw_loaded_o && fw_running_i) ? fw_revision_i : RST_FW_REV;
      else if (bus.addr == ADDR_LIFT_THR)
        rdata_r <= lift_r;
      else if (bus.addr == ADDR_Y_RES)
        rdata_r <= yres_r;
      else if (bus.addr == ADDR_IMG_SIZE)
        rdata_r <= size_r;
      else
        rdata_r <= '0;
    end
  end
  assign bus.rdata = rdata_r;

  // registered outputs
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lift_threshold_o <= RST_LIFT_THR[4:0];
      y_cpi_o <= '0;
      image_3k_o <= 1'b0;
      fw_loaded_o <= 1'b0;
    end
    else
    begin
      lift_threshold_o <= lift_r[4:0];
      y_cpi_o <= indep_axis_i ? 16'(16'(yres_r) * Y_CPI_STEP) : common_cpi_i;
      image_3k_o <= size_r[BIT_IMG_SIZE];
      fw_loaded_o <= (load_cnt_r == img_len);
    end
  end
endmodule

// *** verification/ssc_monitor.sv ***
// concurrent checks on the link between host controller and sensor register bank
`timescale 1ns/10ps
module ssc_monitor
  import ssc_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = 20
) (
  input wire logic mclk_i,              // clock
  input wire logic nrst_i,              // async reset, active low
  input wire logic [7:0] addr,          // device register address
  input wire logic [7:0] wdata,         // device write data
  input wire logic wr,                  // write strobe
  input wire logic rd,                  // read strobe
  input wire logic [7:0] rdata,         // read data
  input wire logic [4:0] lift_threshold_o, // lift threshold field
  input wire logic image_3k_o,          // image size bit
  input wire logic [15:0] y_cpi_o,      // effective y resolution
  input wire logic indep_axis_i,        // independent-axis mode
  input wire logic [15:0] common_cpi_i, // shared resolution
  input wire logic crc_busy_o           // crc test running
);
  // wait window between flag clear and read-back
  localparam int FRM_LO = FRAME_CYCLES;
  localparam int FRM_HI = 3 * FRAME_CYCLES;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // steps of a health check and of command writes
  sequence obs_clear_s;
    wr && addr == ADDR_PROC_OBS && wdata == OBS_CLEAR_VAL;
  endsequence
  sequence obs_read_s;
    rd && addr == ADDR_PROC_OBS;
  endsequence
  sequence crc_start_s;
    wr && addr == ADDR_FWM_ENABLE && wdata == CMD_CRC_START;
  endsequence
  sequence pur_s;
    wr && addr == ADDR_PUR_CMD && wdata == CMD_PUR;
  endsequence
  // register behaviour seen at the link
  health_flags_a: assert property (obs_clear_s ##[FRM_LO:FRM_HI] obs_read_s |=> rdata[5:0] == 6'h3F)
    else $error("frame flags missing after clear");
  crc_busy_a: assert property (crc_start_s |=> crc_busy_o [*8])
    else $error("crc test did not start");
  soft_reset_a: assert property (pur_s |-> ##[2:4] (lift_threshold_o == RST_LIFT_THR[4:0] && !image_3k_o))
    else $error("soft reset did not restore defaults");
  lift_write_a: assert property (wr && addr == ADDR_LIFT_THR ##1 1'b1 |=> lift_threshold_o == $past(wdata[4:0], 2))
    else $error("lift threshold not taken from write");
  lift_read_a: assert property (rd && addr == ADDR_LIFT_THR |=> rdata == {3'b000, lift_threshold_o})
    else $error("lift threshold read mismatch");
  size_read_a: assert property (rd && addr == ADDR_IMG_SIZE |=> rdata == {6'h00, image_3k_o, 1'b0})
    else $error("image size read mismatch");
  reset_lift_a: assert property ($rose(nrst_i) |-> lift_threshold_o == RST_LIFT_THR[4:0])
    else $error("lift threshold reset value wrong");
  y_follow_a: assert property (!indep_axis_i |=> y_cpi_o == $past(common_cpi_i))
    else $error("y resolution not ignored");
endmodule

// *** verification/tb_sensor_status_config_regs.sv ***
// self-checking bench: host controller and sensor bank joined by their link
`timescale 1ns/10ps
module tb_sensor_status_config_regs;
  import ssc_pkg::*;
  localparam int FRM = 20;
  localparam logic [7:0] REV_ARB = 8'h5C; // arbitrary revision code
  logic mclk_i, nrst_i, load_valid_i, fw_running_i, indep_axis_i, sw_wr_i, sw_rd_i, irq_o;
  logic image_3k_o, crc_busy_o, fw_loaded_o;
  logic [7:0] load_byte_i, fw_revision_i, sw_addr_i, v, w, q;
  logic [15:0] common_cpi_i, sw_wdata_i, sw_rdata_o, y_cpi_o, lfsr, crc, d;
  logic [4:0] lift_threshold_o;
  logic [7:0] ra [4] = '{ADDR_LIFT_THR, ADDR_Y_RES, ADDR_IMG_SIZE, ADDR_FW_REV};
  logic [7:0] rv [4] = '{RST_LIFT_THR, RST_Y_RES, RST_IMG_SIZE, RST_FW_REV};
  int n_errors, n_tests;
  ssc_bus_if link ();
  ssc_device #(.FRAME_CYCLES(FRM)) ssc_device_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(link),
    .load_valid_i(load_valid_i), .load_byte_i(load_byte_i), .fw_running_i(fw_running_i),
    .fw_revision_i(fw_revision_i), .indep_axis_i(indep_axis_i), .common_cpi_i(common_cpi_i),
    .lift_threshold_o(lift_threshold_o), .y_cpi_o(y_cpi_o), .image_3k_o(image_3k_o),
    .crc_busy_o(crc_busy_o), .fw_loaded_o(fw_loaded_o));
  ssc_host #(.FRAME_CYCLES(FRM), .CRC_WAIT(1600)) ssc_host_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .bus(link), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .irq_o(irq_o));
  ssc_monitor #(.FRAME_CYCLES(FRM)) ssc_monitor_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .lift_threshold_o(lift_threshold_o), .image_3k_o(image_3k_o), .y_cpi_o(y_cpi_o),
    .indep_axis_i(indep_axis_i), .common_cpi_i(common_cpi_i), .crc_busy_o(crc_busy_o));
  // random source and expected crc
  function automatic logic [15:0] next_lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // two closing bytes that bring the image crc to the pass value
  function automatic logic [15:0] crc_tail(input logic [15:0] c);
    for (int t = 0; t < 65536; t++)
      if (crc_step(crc_step(c, t[15:8]), t[7:0]) == CRC_PASS)
        return t[15:0];
    return 16'h0000;
  endfunction
  // comparison and verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // software port cycles
  task automatic sw_wr(input logic [7:0] a, input logic [15:0] x);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_wdata_i <= x;
    sw_wr_i <= 1'b1;
    @(posedge mclk_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic sw_rd(input logic [7:0] a, output logic [15:0] x);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge mclk_i);
    sw_rd_i <= 1'b0;
    #1 x = sw_rdata_o;
  endtask
  // command with its event enabled, bounded wait, then clear
  task automatic op(input logic [15:0] cm, input logic [15:0] em);
    int k;
    sw_wr(SW_IRQ_ENABLE, em);
    sw_wr(SW_CTRL, cm);
    for (k = 0; k < 4000 && irq_o !== 1'b1; k++)
      @(posedge mclk_i) #1;
    if (k == 4000)
    begin
      n_errors++;
      finish_test();
    end
    sw_wr(SW_IRQ_CLEAR, 16'h0007);
    repeat (3) @(posedge mclk_i);
    #1 chk("irq after clear", 16'h0000, irq_o);
  endtask
  task automatic raw_wr(input logic [7:0] a, input logic [7:0] x);
    sw_wr(SW_RAW_ADDR, {8'h00, a});
    sw_wr(SW_RAW_WDATA, {8'h00, x});
    op(16'h0008, 16'h0004);
  endtask
  task automatic raw_rd(input logic [7:0] a, output logic [7:0] x);
    logic [15:0] r;
    sw_wr(SW_RAW_ADDR, {8'h00, a});
    op(16'h0010, 16'h0004);
    sw_rd(SW_RESULT, r);
    x = r[7:0];
  endtask
  // clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // main sequence
  initial
  begin
    {nrst_i, load_valid_i, fw_running_i, indep_axis_i, sw_wr_i, sw_rd_i} = '0;
    {load_byte_i, sw_addr_i, sw_wdata_i} = '0;
    fw_revision_i = REV_ARB;
    common_cpi_i = 16'h0640;
    lfsr = 16'h46C8;
    n_errors = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk_i);
    #2 nrst_i = 1'b1;
    // reset values
    for (int i = 0; i < 4; i++)
    begin
      raw_rd(ra[i], q);
      chk("reset value", rv[i], q);
    end
    // masked fields and y resolution, corners first
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'hFF : lfsr[7:0];
      w = (i == 1) ? Y_RES_MAX : (i == 2) ? Y_RES_MIN : (v % 8'd41) + 8'd1;
      lfsr = next_lfsr(lfsr);
      raw_wr(ADDR_LIFT_THR, v);
      raw_rd(ADDR_LIFT_THR, q);
      chk("lift", v & MASK_LIFT_THR, q);
      chk("lift out", v[4:0], lift_threshold_o);
      raw_wr(ADDR_IMG_SIZE, v);
      raw_rd(ADDR_IMG_SIZE, q);
      chk("size", v & MASK_IMG_SIZE, q);
      chk("size out", v[1], image_3k_o);
      raw_wr(ADDR_Y_RES, w);
      @(posedge mclk_i);
      indep_axis_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1 chk("y cpi", {8'h00, w} * Y_CPI_STEP, y_cpi_o);
      @(posedge mclk_i);
      indep_axis_i <= 1'b0;
      common_cpi_i <= lfsr;
      repeat (3) @(posedge mclk_i);
      #1 chk("y ignored", lfsr, y_cpi_o);
    end
    raw_wr(ADDR_IMG_SIZE, 8'h00);
    // health check without and with shadow firmware
    for (int f = 0; f < 2; f++)
    begin
      @(posedge mclk_i);
      fw_running_i <= f[0];
      op(16'h0001, 16'h0001);
      sw_rd(SW_RESULT, d);
      chk("flags", {1'b0, f[0], 6'h3F}, d[7:0]);
    end
    raw_rd(ADDR_FW_REV, q);
    chk("rev unloaded", 16'h0000, q);
    // small image ending in two bytes that make it pass, revision, crc test
    crc = CRC_SEED;
    for (int i = 0; i < 1536; i++)
    begin
      @(posedge mclk_i);
      if (i == 1534)
        d = crc_tail(crc);
      w = (i < 1534) ? lfsr[7:0] : (i == 1534) ? d[15:8] : d[7:0];
      load_valid_i <= 1'b1;
      load_byte_i <= w;
      crc = crc_step(crc, w);
      lfsr = next_lfsr(lfsr);
    end
    @(posedge mclk_i);
    load_valid_i <= 1'b0;
    raw_rd(ADDR_FW_REV, q);
    chk("loaded", 16'h0001, fw_loaded_o);
    chk("rev running", fw_revision_i, q);
    @(posedge mclk_i);
    fw_running_i <= 1'b0;
    raw_rd(ADDR_FW_REV, q);
    chk("rev idle", 16'h0000, q);
    op(16'h0002, 16'h0002);
    sw_rd(SW_CRC, d);
    chk("crc", crc, d);
    sw_rd(SW_STATUS, d);
    chk("pass flag", crc === CRC_PASS, d[1]);
    raw_rd(ADDR_CRC_LOW, q);
    chk("crc low", crc[7:0], q);
    raw_rd(ADDR_CRC_HIGH, q);
    chk("crc high", crc[15:8], q);
    // masked event stays silent until enabled
    sw_wr(SW_IRQ_ENABLE, 16'h0000);
    sw_wr(SW_CTRL, 16'h0010);
    repeat (10) @(posedge mclk_i);
    #1 chk("masked irq", 16'h0000, irq_o);
    sw_rd(SW_IRQ_STATUS, d);
    chk("event status", 16'h0004, d & 16'h0004);
    sw_wr(SW_IRQ_ENABLE, 16'h0004);
    repeat (3) @(posedge mclk_i);
    #1 chk("enabled irq", 16'h0001, irq_o);
    sw_wr(SW_IRQ_CLEAR, 16'h0007);
    // soft reset restores defaults, unmapped reads zero
    raw_wr(ADDR_LIFT_THR, 8'h05);
    raw_wr(ADDR_IMG_SIZE, 8'h02);
    raw_wr(ADDR_Y_RES, 8'h29);
    op(16'h0004, 16'h0004);
    raw_rd(ADDR_LIFT_THR, q);
    chk("lift after reset", RST_LIFT_THR, q);
    raw_rd(ADDR_Y_RES, q);
    chk("y after reset", RST_Y_RES, q);
    raw_rd(ADDR_IMG_SIZE, q);
    chk("size after reset", RST_IMG_SIZE, q);
    chk("loaded after reset", 16'h0000, fw_loaded_o);
    raw_rd(8'h55, q);
    chk("unmapped", 16'h0000, q);
    finish_test();
  end
endmodule
